// >>> rtl/system_reset_sequencer.sv
`timescale 1ns/100ps
// Overview of operation
// R01 - After reset starts and oscillator runs, hold core 66 oscillator cycles.
// R02 - Crystal option enabled extends hold to 5000 oscillator cycles.
// R03 - Reset pin still low at count end keeps reset until released.
// R04 - Reset start forces all port pins to input, pull-ups off.
// R05 - Core and peripherals idle in reset; crystal and watchdog oscillators run. Crystal oscillator runs only with the crystal option here.
// R06 - Control registers take reset values; pointers, flags, RAM stay undefined.
// R07 - On release core loads reset vector from fixed address into PC.
// R08 - Register-reinitialising reset selects internal oscillator as system clock.
// R09 - Normal/halt: power-on, brownout, watchdog reset or reset pin start reset.
// R10 - Normal/halt: reset-pin pulses under three clocks are ignored.
// R11 - Debugger reset bit resets everything except the on-chip debugger.
// R12 - Stop: power-on/brownout, debug pin low, filtered reset pin accepted.
// R13 - After supply rises above power-on level, wait for power-on counter.
// R14 - Completed power-on reset sets the power-on flag in watchdog control.
// R15 - Brownout holds reset; on recovery a full reset sequence runs.
// R16 - Stop-mode brownout detection follows its own option bit.
// R17 - Stop recovery keeps registers except watchdog/oscillator control; adds start-up.
// R18 - Reset pin passes a two-stage synchroniser before the width filter.
module system_reset_sequencer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic osc_ready_i,
    input wire logic osc_tick_i,
    input wire logic por_ok_i,
    input wire logic brownout_i,
    input wire logic wdt_timeout_i,
    input wire logic wdt_reset_mode_i,
    input wire logic reset_pin_n_i,
    input wire logic stop_pin_filtered_n_i,
    input wire logic debug_pin_n_i,
    input wire logic debugger_reset_i,
    input wire logic stop_mode_i,
    input wire logic xtal_option_i,
    input wire logic brownout_in_stop_option_i,
    output logic core_reset_o,
    output logic periph_reset_o,
    output logic debugger_reset_o,
    output logic regs_reinit_o,
    output logic stop_recovery_o,
    output logic [15:0] vector_addr_o,
    output logic fetch_vector_o,
    output logic sysclk_sel_ipo_o,
    output logic xtal_osc_run_o,
    output logic wdt_osc_run_o,
    output logic [7:0] gpio_dir_in_o,
    output logic [7:0] gpio_pullup_o,
    output logic [7:0] watchdog_control_reg_o,
    output logic [7:0] oscillator_control_reg_o,
    output logic brownout_enable_o
);
    typedef enum logic [2:0] {
        ST_RUN,
        ST_SUPPLY,
        ST_WAIT_OSC,
        ST_HOLD,
        ST_PIN_WAIT,
        ST_FETCH
    } state_t;

    typedef struct packed {
        state_t st;
        rst_seq_pkg::cause_t cause;
        logic reinit;
        logic [7:0] gpio_in;
        logic [7:0] gpio_pu;
        logic [7:0] watchdog_control_reg;
        logic [7:0] oscillator_control_reg;
        logic sel_ipo;
        logic fetch;
        logic [2:0] dsync;
        logic dbg_meta;
        logic dbg_sync;
        logic stop_meta;
        logic stop_sync;
    } seq_t;
    seq_t s_q, s_d;

    logic pin_sync_n;
    logic pin_low_valid;
    logic cnt_load;
    logic [rst_seq_pkg::CNT_W-1:0] cnt_value;
    logic cnt_done;
    logic bo_active;
    logic stop_pin_low;
    logic run_cause;
    rst_seq_pkg::cause_t run_code;

    // ==========================================================
    // Helpers
    // ==========================================================
    pin_sync_filter u_pin (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_n_i(reset_pin_n_i),
        .pin_sync_n_o(pin_sync_n),
        .valid_low_o(pin_low_valid)
    );

    hold_counter u_cnt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(cnt_load),
        .value_i(cnt_value),
        .tick_i(osc_tick_i),
        .done_o(cnt_done)
    );

    // ==========================================================
    // Reset source selection
    // ==========================================================
    // Brownout only counts in stop when its option allows it
    assign bo_active = brownout_i && (!s_q.stop_sync || brownout_in_stop_option_i); // R16
    // Analog-filtered pin used in stop, where clocks are halted
    assign stop_pin_low = s_q.stop_sync && !stop_pin_filtered_n_i; // R12

    always_comb begin
        run_cause = 1'b1;
        run_code = rst_seq_pkg::CAUSE_NONE;
        if (!por_ok_i || bo_active) begin
            run_code = rst_seq_pkg::CAUSE_POR; // R09 R12 R15
        end else if (s_q.stop_sync && s_q.dsync[0] == 1'b0) begin
            run_code = rst_seq_pkg::CAUSE_STOP; // R12
        end else if (stop_pin_low) begin
            run_code = rst_seq_pkg::CAUSE_PIN; // R12
        end else if (!s_q.stop_sync && pin_low_valid) begin
            run_code = rst_seq_pkg::CAUSE_PIN; // R09 R10
        end else if (!s_q.stop_sync && wdt_timeout_i && wdt_reset_mode_i) begin
            run_code = rst_seq_pkg::CAUSE_WDT; // R09
        end else if (!s_q.stop_sync && debugger_reset_i) begin
            run_code = rst_seq_pkg::CAUSE_DBG; // R11
        end else begin
            run_cause = 1'b0;
        end
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // Hold length: crystal option picks the long hold; stop recovery overrides it with normal hold plus start-up
    always_comb begin
        cnt_value = xtal_option_i ? rst_seq_pkg::HOLD_XTAL : rst_seq_pkg::HOLD_NORMAL; // R01 R02
        if (s_q.cause == rst_seq_pkg::CAUSE_STOP) begin
            cnt_value = rst_seq_pkg::HOLD_NORMAL + rst_seq_pkg::STOP_EXTRA; // R17
        end
    end

    always_comb begin
        s_d = s_q;
        cnt_load = 1'b0;
        s_d.fetch = 1'b0;
        s_d.dbg_meta = debug_pin_n_i;
        s_d.dbg_sync = s_q.dbg_meta;
        s_d.stop_meta = stop_mode_i;
        s_d.stop_sync = s_q.stop_meta;
        s_d.dsync = {s_q.dsync[1:0], s_q.dbg_sync};
        case (s_q.st)
            ST_RUN: begin
                if (run_cause) begin
                    s_d.cause = run_code;
                    s_d.reinit = (run_code != rst_seq_pkg::CAUSE_STOP);
                    // Ports go to input, pull-ups off, at once
                    s_d.gpio_in = '1; // R04
                    s_d.gpio_pu = '0; // R04
                    s_d.st = (run_code == rst_seq_pkg::CAUSE_POR) ? ST_SUPPLY : ST_WAIT_OSC;
                end
            end
            ST_SUPPLY: begin
                // Delay measured from supply crossing the power-on level
                if (por_ok_i && !bo_active) begin
                    s_d.st = ST_WAIT_OSC; // R13 R15
                end
            end
            ST_WAIT_OSC: begin
                if (!por_ok_i || bo_active) begin
                    s_d.st = ST_SUPPLY; // R15
                end else if (osc_ready_i) begin
                    cnt_load = 1'b1; // R01
                    s_d.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!por_ok_i || bo_active) begin
                    s_d.st = ST_SUPPLY; // R15
                end else if (cnt_done) begin
                    s_d.st = ST_PIN_WAIT; // R13
                end
            end
            ST_PIN_WAIT: begin
                if (pin_sync_n) begin
                    s_d.st = ST_FETCH; // R03
                    // Watchdog and oscillator control always reload
                    s_d.watchdog_control_reg = rst_seq_pkg::WATCHDOG_CONTROL_REG_RST; // R06 R17
                    s_d.oscillator_control_reg = rst_seq_pkg::OSCILLATOR_CONTROL_REG_RST; // R08 R17
                    s_d.sel_ipo = 1'b1; // R08
                    case (s_q.cause)
                        rst_seq_pkg::CAUSE_POR:
                            s_d.watchdog_control_reg[rst_seq_pkg::POR_FLAG_BIT] = 1'b1; // R14
                        rst_seq_pkg::CAUSE_STOP:
                            s_d.watchdog_control_reg[rst_seq_pkg::STOP_FLAG_BIT] = 1'b1;
                        rst_seq_pkg::CAUSE_WDT:
                            s_d.watchdog_control_reg[rst_seq_pkg::WDT_FLAG_BIT] = 1'b1;
                        rst_seq_pkg::CAUSE_PIN:
                            s_d.watchdog_control_reg[rst_seq_pkg::EXT_FLAG_BIT] = 1'b1;
                        default: begin
                        end
                    endcase
                end
            end
            ST_FETCH: begin
                s_d.fetch = 1'b1; // R07
                s_d.st = ST_RUN;
            end
            default: s_d.st = ST_RUN;
        endcase
        if (s_q.st == ST_RUN && !run_cause) begin
            s_d.sel_ipo = s_q.sel_ipo;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '{st: ST_SUPPLY, cause: rst_seq_pkg::CAUSE_POR, reinit: 1'b1,
                gpio_in: 8'hFF, gpio_pu: 8'h00, watchdog_control_reg: rst_seq_pkg::WATCHDOG_CONTROL_REG_RST,
                oscillator_control_reg: rst_seq_pkg::OSCILLATOR_CONTROL_REG_RST, sel_ipo: 1'b1, fetch: 1'b0,
                dsync: 3'h7, dbg_meta: 1'b1, dbg_sync: 1'b1,
                stop_meta: 1'b0, stop_sync: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Core idles in every state but run; peripherals idle in every state but run and fetch
    assign core_reset_o = (s_q.st != ST_RUN); // R05
    assign periph_reset_o = (s_q.st != ST_RUN) && (s_q.st != ST_FETCH); // R05
    // Debugger only resets on power loss, never on its own request
    assign debugger_reset_o = (s_q.st != ST_RUN) && (s_q.cause == rst_seq_pkg::CAUSE_POR); // R11
    assign regs_reinit_o = core_reset_o && s_q.reinit; // R06
    assign stop_recovery_o = core_reset_o && !s_q.reinit; // R17
    assign vector_addr_o = rst_seq_pkg::RESET_VECTOR_ADDR; // R07
    assign fetch_vector_o = s_q.fetch; // R07
    assign sysclk_sel_ipo_o = s_q.sel_ipo; // R08
    // Oscillators are never gated by the sequencer
    assign xtal_osc_run_o = xtal_option_i; // R05
    assign wdt_osc_run_o = 1'b1; // R05
    assign gpio_dir_in_o = s_q.gpio_in;
    assign gpio_pullup_o = s_q.gpio_pu;
    assign watchdog_control_reg_o = s_q.watchdog_control_reg;
    assign oscillator_control_reg_o = s_q.oscillator_control_reg;
    // Synchronised stop level, so the raw stop_mode_i input never reaches logic
    assign brownout_enable_o = !s_q.stop_sync || brownout_in_stop_option_i; // R16

    // ==========================================================
    // Checks
    // ==========================================================
    chk_pin_holds_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_q.st == ST_PIN_WAIT && !pin_sync_n) |=> core_reset_o) // R03
        else $error("reset released while pin low");
    chk_gpio_forced_input: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_q.st == ST_HOLD) |-> (gpio_dir_in_o == 8'hFF && gpio_pullup_o == 8'h00)) // R04
        else $error("ports not forced to input");
    chk_fetch_after_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_q.st == ST_FETCH) |=> fetch_vector_o && !core_reset_o) // R07
        else $error("vector fetch not issued");
    chk_ipo_after_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(core_reset_o) |-> sysclk_sel_ipo_o) // R08
        else $error("clock not internal after reset");
    chk_por_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($fell(core_reset_o) && s_q.cause == rst_seq_pkg::CAUSE_POR)
        |-> watchdog_control_reg_o[rst_seq_pkg::POR_FLAG_BIT]) // R14
        else $error("power-on flag not set");
    chk_brownout_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_q.st == ST_HOLD && !por_ok_i) |=> s_q.st == ST_SUPPLY) // R15
        else $error("brownout did not restart sequence");
    chk_debugger_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (core_reset_o && s_q.cause == rst_seq_pkg::CAUSE_DBG) |-> !debugger_reset_o) // R11
        else $error("debugger reset by own request");
    chk_hold_min_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_q.st == ST_HOLD && !cnt_done) |=> core_reset_o) // R01 R02
        else $error("hold ended early");
endmodule

// >>> rtl/rst_seq_pkg.sv
package rst_seq_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    // Hold counts in internal_precision_osc cycles
    localparam int unsigned HOLD_NORMAL_CYC = 66;
    localparam int unsigned HOLD_XTAL_CYC = 5000;
    localparam int unsigned STOP_EXTRA_CYC = 16;
    localparam int unsigned CNT_W = 13;
    localparam logic [CNT_W-1:0] HOLD_NORMAL = CNT_W'(HOLD_NORMAL_CYC);
    localparam logic [CNT_W-1:0] HOLD_XTAL = CNT_W'(HOLD_XTAL_CYC);
    localparam logic [CNT_W-1:0] STOP_EXTRA = CNT_W'(STOP_EXTRA_CYC);
    // Pin pulses shorter than this many clocks are ignored
    localparam int unsigned PIN_MIN_CYC = 3;
    localparam int unsigned FILT_W = 2;
    // ==========================================================
    // Register reset values and positions
    // ==========================================================
    localparam int unsigned GPIO_W = 8;
    localparam logic [7:0] WATCHDOG_CONTROL_REG_RST = 8'h00;
    localparam logic [7:0] OSCILLATOR_CONTROL_REG_RST = 8'hA0;
    localparam int unsigned POR_FLAG_BIT = 7;
    localparam int unsigned STOP_FLAG_BIT = 6;
    localparam int unsigned WDT_FLAG_BIT = 5;
    localparam int unsigned EXT_FLAG_BIT = 4;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
    // Reset cause codes
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_POR,
        CAUSE_WDT,
        CAUSE_PIN,
        CAUSE_DBG,
        CAUSE_STOP
    } cause_t;
endpackage

// >>> rtl/pin_sync_filter.sv
`timescale 1ns/100ps
// Two-stage synchroniser, then a minimum-width filter on the low level
module pin_sync_filter (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic pin_n_i,
    output logic pin_sync_n_o,
    output logic valid_low_o
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic [rst_seq_pkg::FILT_W-1:0] cnt;
        logic valid;
    } filt_t;
    filt_t s_q, s_d;

    // ==========================================================
    // Filter
    // ==========================================================
    // Meta stage feeds only the second stage
    always_comb begin
        s_d = s_q;
        s_d.meta = pin_n_i; // R18
        s_d.sync = s_q.meta; // R18
        if (s_q.sync) begin
            s_d.cnt = '0;
            s_d.valid = 1'b0;
        end else if (s_q.cnt != rst_seq_pkg::FILT_W'(rst_seq_pkg::PIN_MIN_CYC - 1)) begin
            s_d.cnt = s_q.cnt + 1'b1; // R10
        end else begin
            s_d.valid = 1'b1; // R10
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '{meta: 1'b1, sync: 1'b1, cnt: '0, valid: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_sync_n_o = s_q.sync;
    assign valid_low_o = s_q.valid;

    chk_short_pulse_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(s_q.valid) |-> $past(!s_q.sync, 1) && $past(!s_q.sync, 2) && $past(!s_q.sync, 3))
        else $error("filter accepted a short pulse"); // R10
endmodule

// >>> rtl/hold_counter.sv
`timescale 1ns/100ps
// Down-counter of oscillator cycles; done when zero is reached
module hold_counter (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [rst_seq_pkg::CNT_W-1:0] value_i,
    input wire logic tick_i,
    output logic done_o
);
    typedef struct packed {
        logic [rst_seq_pkg::CNT_W-1:0] cnt;
    } cnt_t;
    cnt_t s_q, s_d;

    // ==========================================================
    // Count
    // ==========================================================
    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.cnt = value_i;
        end else if (tick_i && s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_o = (s_q.cnt == '0) && !load_i;
endmodule

// >>> verification/supply_pin_model.sv
`timescale 1ns/100ps
// ==========================================================
// Supply monitors, oscillator and reset-pin driver
// ==========================================================
module supply_pin_model (
    input wire logic clk_i,
    input wire logic [1:0] gap_i,
    input wire logic supply_on_i,
    input wire logic pin_low_i,
    output logic por_ok_o,
    output logic brownout_o,
    output logic osc_ready_o,
    output logic osc_tick_o,
    output logic reset_pin_n_o,
    output logic stop_pin_filtered_n_o
);
    logic [3:0] up_q;
    logic [1:0] gap_q;
    // Everything starts unpowered
    initial begin
        up_q = 4'h0;
        gap_q = 2'h0;
        por_ok_o = 1'b0;
        brownout_o = 1'b0;
        osc_ready_o = 1'b0;
        osc_tick_o = 1'b0;
    end
    // Pin has a pull-up, so a released pin reads high
    assign reset_pin_n_o = ~pin_low_i;
    assign stop_pin_filtered_n_o = ~pin_low_i;
    // Supply ramps slowly; oscillator starts late and stops with the supply
    always @(negedge clk_i) begin
        brownout_o <= ~supply_on_i;
        por_ok_o <= supply_on_i && (up_q >= 4'h4);
        up_q <= supply_on_i ? ((up_q == 4'hF) ? up_q : up_q + 4'h1) : 4'h0;
        osc_ready_o <= supply_on_i && (up_q == 4'hF);
        osc_tick_o <= 1'b0;
        gap_q <= gap_q + 2'h1;
        if (osc_ready_o && gap_q >= gap_i) begin
            osc_tick_o <= 1'b1;
            gap_q <= 2'h0;
        end
    end
endmodule

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
    // ==========================================================
    // Signals
    // ==========================================================
    typedef struct {int lo; int hi; int flag; logic stp; logic dbg;} note_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wdt_timeout_i = 1'b0, wdt_reset_mode_i = 1'b0, debug_pin_n_i = 1'b1;
    logic debugger_reset_i = 1'b0, stop_mode_i = 1'b0, xtal_option_i = 1'b0;
    logic brownout_in_stop_option_i = 1'b0, supply_on = 1'b0, pin_low = 1'b0;
    logic [1:0] gap = 2'h1;
    logic por_ok_i, brownout_i, osc_ready_i, osc_tick_i, reset_pin_n_i, stop_pin_filtered_n_i;
    logic core_reset_o, periph_reset_o, debugger_reset_o, regs_reinit_o, stop_recovery_o;
    logic fetch_vector_o, sysclk_sel_ipo_o, xtal_osc_run_o, wdt_osc_run_o, brownout_enable_o;
    logic [15:0] vector_addr_o;
    logic [7:0] gpio_dir_in_o, gpio_pullup_o, watchdog_control_reg_o, oscillator_control_reg_o;
    logic [31:0] seed = 32'h9B50;
    note_t notes[$];
    int ticks = 0, err_count = 0, tests_run = 0;
    logic seen_dbg = 1'b0, seen_stp = 1'b0;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    system_reset_sequencer u_system_reset_sequencer (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .osc_ready_i(osc_ready_i), .osc_tick_i(osc_tick_i), .por_ok_i(por_ok_i),
        .brownout_i(brownout_i), .wdt_timeout_i(wdt_timeout_i),
        .wdt_reset_mode_i(wdt_reset_mode_i), .reset_pin_n_i(reset_pin_n_i),
        .stop_pin_filtered_n_i(stop_pin_filtered_n_i), .debug_pin_n_i(debug_pin_n_i),
        .debugger_reset_i(debugger_reset_i), .stop_mode_i(stop_mode_i),
        .xtal_option_i(xtal_option_i), .brownout_in_stop_option_i(brownout_in_stop_option_i),
        .core_reset_o(core_reset_o), .periph_reset_o(periph_reset_o),
        .debugger_reset_o(debugger_reset_o), .regs_reinit_o(regs_reinit_o),
        .stop_recovery_o(stop_recovery_o), .vector_addr_o(vector_addr_o),
        .fetch_vector_o(fetch_vector_o), .sysclk_sel_ipo_o(sysclk_sel_ipo_o),
        .xtal_osc_run_o(xtal_osc_run_o), .wdt_osc_run_o(wdt_osc_run_o),
        .gpio_dir_in_o(gpio_dir_in_o), .gpio_pullup_o(gpio_pullup_o),
        .watchdog_control_reg_o(watchdog_control_reg_o),
        .oscillator_control_reg_o(oscillator_control_reg_o),
        .brownout_enable_o(brownout_enable_o));
    supply_pin_model u_supply_pin_model (.clk_i(clk_i), .gap_i(gap), .supply_on_i(supply_on),
        .pin_low_i(pin_low), .por_ok_o(por_ok_i), .brownout_o(brownout_i),
        .osc_ready_o(osc_ready_i), .osc_tick_o(osc_tick_i), .reset_pin_n_o(reset_pin_n_i),
        .stop_pin_filtered_n_o(stop_pin_filtered_n_i));
    // ==========================================================
    // Compare and report
    // ==========================================================
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_rng(input int got, input int lo, input int hi, input string what);
        tests_run++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic summarize();
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Monitor: counts oscillator cycles held, checks each release against the oldest note
    always @(negedge clk_i) begin
        note_t n;
        if (fetch_vector_o === 1'b1) begin
            seen_stp = seen_stp | (stop_recovery_o === 1'b1);
            if (notes.size() == 0) begin
                cmp_bit(1'b0, 1'b1, "fetch without cause");
            end else begin
                n = notes.pop_front();
                cmp_rng(ticks, n.lo, n.hi, "hold cycles");
                cmp_bit(seen_dbg, n.dbg, "debugger reset");
                cmp_bit(seen_stp, n.stp, "stop recovery");
                if (n.flag >= 0) cmp_bit(watchdog_control_reg_o[n.flag], 1'b1, "flag");
                cmp_val(vector_addr_o, rst_seq_pkg::RESET_VECTOR_ADDR, "vector");
                cmp_bit(sysclk_sel_ipo_o, 1'b1, "clock select");
                cmp_val(16'(oscillator_control_reg_o), 16'h00A0, "osc reg");
            end
        end
        if (core_reset_o !== 1'b1) begin
            ticks = 0;
            seen_dbg = 1'b0;
            seen_stp = 1'b0;
        end else begin
            if (osc_ready_i && osc_tick_i) ticks++;
            seen_dbg = seen_dbg | (debugger_reset_o === 1'b1);
            seen_stp = seen_stp | (stop_recovery_o === 1'b1);
        end
    end
    // ==========================================================
    // Stimulus helpers
    // ==========================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // New random oscillator spacing and expectation for the next release
    task automatic expect_rel(input int lo, input int hi, input int flag, input logic stp,
                              input logic dbg);
        note_t n;
        seed = xs(seed);
        gap = 2'(seed % 3) + 2'h1;
        n = '{lo, hi, flag, stp, dbg};
        notes.push_back(n);
    endtask
    task automatic trig();
        int i;
        i = 0;
        while (core_reset_o !== 1'b1 && i < 20) begin
            @(negedge clk_i);
            i++;
        end
        @(negedge clk_i);
        cmp_bit(core_reset_o, 1'b1, "reset entered");
        cmp_val(16'(gpio_dir_in_o), 16'h00FF, "gpio dir");
        cmp_val(16'(gpio_pullup_o), 16'h0000, "gpio pull-up");
        cmp_bit(periph_reset_o, 1'b1, "periph idle");
        cmp_bit(wdt_osc_run_o, 1'b1, "wdt osc");
        cmp_bit(xtal_osc_run_o, xtal_option_i, "xtal osc");
    endtask
    // Bounded wait for release; the extra edge lets the monitor see the fetch
    task automatic wait_done(input string name);
        int i;
        i = 0;
        while (core_reset_o !== 1'b0 && i < 25000) begin
            @(negedge clk_i);
            i++;
        end
        @(negedge clk_i);
        cmp_bit(notes.size() == 0, 1'b1, "release seen");
        $display("test %s done", name);
    endtask
    task automatic quiet(input string name);
        repeat (20) @(negedge clk_i);
        cmp_bit(core_reset_o, 1'b0, "refused source");
        $display("test %s done", name);
    endtask
    task automatic pin(input int n);
        pin_low = 1'b1;
        repeat (n) @(negedge clk_i);
        pin_low = 1'b0;
    endtask
    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        // Longest path is a crystal hold of 5000 ticks at four clocks each
        repeat (90000) @(posedge clk_i);
        err_count++;
        $display("MISMATCH t=%0t run timed out", $time);
        summarize();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        expect_rel(66, 69, rst_seq_pkg::POR_FLAG_BIT, 1'b0, 1'b1);
        repeat (20) @(negedge clk_i);
        supply_on = 1'b1;
        wait_done("power_on");
        pin(2);
        quiet("narrow_pin");
        expect_rel(66, 69, rst_seq_pkg::EXT_FLAG_BIT, 1'b0, 1'b0);
        pin(3);
        trig();
        wait_done("pin_three_clocks");
        expect_rel(66, 100000, rst_seq_pkg::EXT_FLAG_BIT, 1'b0, 1'b0);
        pin_low = 1'b1;
        trig();
        repeat (400) @(negedge clk_i);
        cmp_bit(core_reset_o, 1'b1, "pin still low");
        pin_low = 1'b0;
        wait_done("pin_held");
        wdt_timeout_i = 1'b1;
        @(negedge clk_i);
        wdt_timeout_i = 1'b0;
        quiet("wdt_no_reset_mode");
        wdt_reset_mode_i = 1'b1;
        xtal_option_i = 1'b1;
        expect_rel(5000, 5003, rst_seq_pkg::WDT_FLAG_BIT, 1'b0, 1'b0);
        wdt_timeout_i = 1'b1;
        @(negedge clk_i);
        wdt_timeout_i = 1'b0;
        trig();
        wait_done("wdt_xtal");
        xtal_option_i = 1'b0;
        expect_rel(66, 69, -1, 1'b0, 1'b0);
        debugger_reset_i = 1'b1;
        @(negedge clk_i);
        debugger_reset_i = 1'b0;
        trig();
        wait_done("debugger_bit");
        expect_rel(66, 69, rst_seq_pkg::POR_FLAG_BIT, 1'b0, 1'b1);
        supply_on = 1'b0;
        trig();
        repeat (30) @(negedge clk_i);
        supply_on = 1'b1;
        wait_done("brownout");
        for (int k = 0; k < 4; k++) begin
            stop_mode_i = k[1];
            brownout_in_stop_option_i = k[0];
            repeat (4) @(negedge clk_i);
            cmp_bit(brownout_enable_o, ~k[1] | k[0], "brownout enable");
        end
        $display("test brownout_option done");
        brownout_in_stop_option_i = 1'b0;
        expect_rel(82, 85, rst_seq_pkg::STOP_FLAG_BIT, 1'b1, 1'b0);
        debug_pin_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        debug_pin_n_i = 1'b1;
        trig();
        stop_mode_i = 1'b0;
        wait_done("stop_debug_pin");
        stop_mode_i = 1'b1;
        repeat (4) @(negedge clk_i);
        expect_rel(66, 69, rst_seq_pkg::EXT_FLAG_BIT, 1'b0, 1'b0);
        pin_low = 1'b1;
        trig();
        pin_low = 1'b0;
        stop_mode_i = 1'b0;
        wait_done("stop_reset_pin");
        summarize();
    end
endmodule
